//--- sca_pkg.sv
package sca_pkg;
  // core clock, 200 MHz
  localparam int CLK_PERIOD_PS = 5000;
  // link clock period used to place the 90 degree capture point
  localparam int LINK_PERIOD_NS = 80;
  localparam int TX_QUARTER_CYCLES = (LINK_PERIOD_NS * 1000 / 4) / CLK_PERIOD_PS;

  // character framing
  localparam int CHAR_BITS = 10;
  localparam int HALF_BITS = 5;
  localparam logic [3:0] CHAR_LAST_IDX = 4'h9;
  localparam logic [3:0] SECOND_HALF_IDX = 4'h5;
  localparam logic [3:0] FIRST_LAST_IDX = 4'h4;
  // comma prefix 0011111, lsb holds the first bit on the wire
  localparam logic [6:0] COMMA_PREFIX = 7'h7C;
  // bit index of the seventh comma bit inside its character
  localparam logic [3:0] COMMA_LAST_IDX = 4'h6;

  // frequency lock after power-up
  localparam int LOCK_TIME_US = 500;
  localparam int LOCK_CYCLES = (LOCK_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;

  // bit sync: regain within the documented maximum
  localparam int BIT_SYNC_MAX_BITS = 2500;
  localparam int RESYNC_BITS = 20;
  localparam int LINK_GAP_NS = 400;
  localparam int LINK_GAP_CYCLES = (LINK_GAP_NS * 1000) / CLK_PERIOD_PS;

  // typical latencies, kept for reference; the bench does not use them
  localparam int TX_LATENCY_NS = 4;
  localparam int RX_LATENCY_NS = 16;

  // reset and phase values of the recovered clock pair
  localparam logic [1:0] PAIR_RESET = 2'h1;
  localparam logic [1:0] PAIR_FIRST = 2'h2;
  localparam logic [1:0] PAIR_SECOND = 2'h1;

  // receive output stage, gray along idle -> first -> second
  typedef enum logic [1:0] {
    OUT_IDLE = 2'h0,
    OUT_FIRST = 2'h1,
    OUT_SECOND = 2'h3
  } sca_out_state_t;

  // transmit capture, idle -> first or second -> idle; gray only between idle and first
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_FIRST = 2'h1,
    TX_SECOND = 2'h3
  } sca_tx_state_t;
endpackage

//--- sca_tx_serializer.sv
`timescale 1ns/1ps
module sca_tx_serializer (
  input wire logic clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic load, // one-cycle pulse, half captured
  input wire logic [4:0] half, // captured half-character
  output logic serialBit, // serial line level
  output logic bitStrobe // high while serialBit holds a bit
);
  logic [4:0] shiftReg;
  logic [2:0] bitsLeft;
  logic [4:0] next_shiftReg;
  logic [2:0] next_bitsLeft;
  logic next_serialBit;
  logic next_bitStrobe;

  // start on load right away to keep latency to one cycle
  always_comb begin
    next_shiftReg = shiftReg;
    next_bitsLeft = bitsLeft;
    next_serialBit = serialBit;
    next_bitStrobe = 1'b0;
    if (load) begin
      next_serialBit = half[0]; // see [RQ13]
      next_shiftReg = {1'b0, half[4:1]};
      next_bitsLeft = 3'(sca_pkg::HALF_BITS - 1);
      next_bitStrobe = 1'b1; // see [RQ12]
    end else if (bitsLeft != 3'h0) begin
      next_serialBit = shiftReg[0]; // see [RQ13]
      next_shiftReg = {1'b0, shiftReg[4:1]};
      next_bitsLeft = bitsLeft - 3'h1;
      next_bitStrobe = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= 5'h0;
      bitsLeft <= 3'h0;
      serialBit <= 1'b0;
      bitStrobe <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      bitsLeft <= next_bitsLeft;
      serialBit <= next_serialBit;
      bitStrobe <= next_bitStrobe;
    end
  end

  a_bit_zero_first: assert property (@(posedge clk) disable iff (rst) // see [RQ13]
    load |=> bitStrobe && serialBit == $past(half[0]))
    else $error("bit zero did not leave first");
  a_five_bits_out: assert property (@(posedge clk) disable iff (rst) // see [RQ13]
    load ##1 !load [*4] |-> ##1 bitStrobe && serialBit == $past(half[4], 4))
    else $error("bit four not last of the half");
  c_half_sent: cover property (@(posedge clk) disable iff (rst) load ##1 bitStrobe [*5] ##1 !bitStrobe);
endmodule // sca_tx_serializer

//--- sca_serdes_align.sv
`timescale 1ns/1ps
// Contract
// [RQ1] rebuild 10-bit characters from serial bits
// [RQ2] detect comma prefix 0011111 as marker
// [RQ3] comma first bit lands on bit zero
// [RQ4] stretch byte clock, never sliver it
// [RQ5] realigned before second ordered set after comma
// [RQ6] second comma rises with clock phase one
// [RQ7] far end never sends back-to-back commas
// [RQ8] character leaves as two 5-bit halves
// [RQ9] each channel owns its own clock pair
// [RQ10] far end drives one shared transmit clock
// [RQ11] capture transmit halves 90 degrees shifted
// [RQ12] transmit latency about five bit times
// [RQ13] transmit bit zero leaves the serializer first
// [RQ14] first received bit appears on bit zero
// [RQ15] hold outputs invalid until frequency lock
// [RQ16] regain bit sync within 2500 bits
// [RQ17] receive latency about twenty bit times
// [RQ18] far end captures on either clock scheme
// [RQ19] far end puts first half at rising edge
// [RQ20] clock pair runs 180 degrees apart
// [RQ21] data before first comma is unaligned
module sca_serdes_align #(
  parameter int LOCK_CYCLES = sca_pkg::LOCK_CYCLES // lock wait, shorten in simulation
) (
  input wire logic clk, // core clock, 200 MHz
  input wire logic rst, // async reset, high
  input wire logic rxBitClk, // recovered bit clock, pin
  input wire logic rxBitIn, // recovered serial data, pin
  input wire logic sharedTransmitByteClock, // transmit byte clock, pin
  input wire logic [4:0] txHalfIn, // transmit half-character, pin
  output logic [4:0] rxHalf, // recovered half-character
  output logic [1:0] recoveredByteClockPair, // recovered byte clocks
  output logic rxAligned, // comma seen, boundary valid
  output logic rxLocked, // frequency lock reached
  output logic rxBitSync, // bit clock present and settled
  output logic txSerial, // serial transmit bit
  output logic txSerialStrobe // serial bit valid
);
  // pin synchronisers; first stage feeds only the second
  logic [1:0] bitClkSync;
  logic [1:0] bitDatSync;
  logic [1:0] txClkSync;
  logic [4:0] txDatMeta;
  logic [4:0] txDat;
  logic bitClkPrev;
  logic txClkPrev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitClkSync <= 2'h0;
      bitDatSync <= 2'h0;
      txClkSync <= 2'h0;
      txDatMeta <= 5'h0;
      txDat <= 5'h0;
      bitClkPrev <= 1'b0;
      txClkPrev <= 1'b0;
    end else begin
      bitClkSync <= {bitClkSync[0], rxBitClk};
      bitDatSync <= {bitDatSync[0], rxBitIn};
      txClkSync <= {txClkSync[0], sharedTransmitByteClock};
      txDatMeta <= txHalfIn;
      txDat <= txDatMeta;
      bitClkPrev <= bitClkSync[1];
      txClkPrev <= txClkSync[1];
    end
  end

  logic bitTick;
  logic txRise;
  logic txFall;
  assign bitTick = bitClkSync[1] & ~bitClkPrev;
  assign txRise = txClkSync[1] & ~txClkPrev;
  assign txFall = ~txClkSync[1] & txClkPrev;

  // frequency lock timer after reset
  logic [16:0] lockCnt;
  logic [16:0] next_lockCnt;
  logic next_rxLocked;

  always_comb begin
    next_lockCnt = lockCnt;
    next_rxLocked = rxLocked;
    if (!rxLocked) begin
      if (lockCnt == 17'(LOCK_CYCLES - 1)) begin
        next_rxLocked = 1'b1; // see [RQ15]
      end else begin
        next_lockCnt = lockCnt + 17'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockCnt <= 17'h0;
      rxLocked <= 1'b0;
    end else begin
      lockCnt <= next_lockCnt;
      rxLocked <= next_rxLocked;
    end
  end

  // bit sync monitor: a stalled bit clock means a phase jump or loss
  logic [6:0] gapCnt;
  logic [4:0] syncBits;
  logic [6:0] next_gapCnt;
  logic [4:0] next_syncBits;
  logic next_rxBitSync;
  logic linkLost;

  always_comb begin
    next_gapCnt = gapCnt;
    next_syncBits = syncBits;
    next_rxBitSync = rxBitSync;
    linkLost = gapCnt == 7'(sca_pkg::LINK_GAP_CYCLES);
    if (bitTick) begin
      next_gapCnt = 7'h0;
    end else if (!linkLost) begin
      next_gapCnt = gapCnt + 7'h1;
    end
    if (linkLost) begin
      next_rxBitSync = 1'b0;
      next_syncBits = 5'h0;
    end else if (bitTick && !rxBitSync) begin
      // resync well inside the maximum bit count
      if (syncBits == 5'(sca_pkg::RESYNC_BITS - 1)) begin
        next_rxBitSync = 1'b1; // see [RQ16]
      end else begin
        next_syncBits = syncBits + 5'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapCnt <= 7'h0;
      syncBits <= 5'h0;
      rxBitSync <= 1'b0;
    end else begin
      gapCnt <= next_gapCnt;
      syncBits <= next_syncBits;
      rxBitSync <= next_rxBitSync;
    end
  end

  // character assembly and comma search
  logic [9:0] shiftReg;
  logic [3:0] bitIdx;
  logic [9:0] next_shiftReg;
  logic [3:0] next_bitIdx;
  logic next_rxAligned;
  logic [3:0] idxInc;
  logic commaSeen;
  logic charDone;
  logic realign;

  always_comb begin
    next_shiftReg = shiftReg;
    next_bitIdx = bitIdx;
    next_rxAligned = rxAligned;
    idxInc = (bitIdx == sca_pkg::CHAR_LAST_IDX) ? 4'h0 : bitIdx + 4'h1;
    commaSeen = 1'b0;
    charDone = 1'b0;
    realign = 1'b0;
    if (bitTick) begin
      // newest bit at the top, so bit zero is the oldest
      next_shiftReg = {bitDatSync[1], shiftReg[9:1]}; // see [RQ1] [RQ14]
      commaSeen = next_shiftReg[9:3] == sca_pkg::COMMA_PREFIX; // see [RQ2]
      if (commaSeen) begin
        next_bitIdx = sca_pkg::COMMA_LAST_IDX; // see [RQ3]
        realign = idxInc != sca_pkg::COMMA_LAST_IDX;
        next_rxAligned = 1'b1;
      end else begin
        next_bitIdx = idxInc;
      end
      charDone = next_bitIdx == sca_pkg::CHAR_LAST_IDX; // see [RQ1]
    end
    if (!rxBitSync) begin
      next_rxAligned = 1'b0; // see [RQ21]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= 10'h0;
      bitIdx <= 4'h0;
      rxAligned <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      bitIdx <= next_bitIdx;
      rxAligned <= next_rxAligned;
    end
  end

  // output stage; clocks hold while idle, which is the stretch
  sca_pkg::sca_out_state_t outState;
  sca_pkg::sca_out_state_t next_outState;
  logic [3:0] outPhase;
  logic [9:0] charBuf;
  logic [9:0] pendBuf;
  logic charPending;
  logic [3:0] next_outPhase;
  logic [9:0] next_charBuf;
  logic [9:0] next_pendBuf;
  logic next_charPending;
  logic [4:0] next_rxHalf;
  logic [1:0] next_pair;
  logic atBoundary;
  logic start;

  always_comb begin
    next_outState = outState;
    next_outPhase = outPhase;
    next_charBuf = charBuf;
    next_pendBuf = pendBuf;
    next_charPending = charPending;
    next_rxHalf = rxHalf;
    next_pair = recoveredByteClockPair;
    atBoundary = outState == sca_pkg::OUT_IDLE || outPhase == sca_pkg::CHAR_LAST_IDX;
    // a realign drops the misframed waiting character
    start = bitTick && rxLocked && atBoundary && (charDone || (charPending && !realign)); // see [RQ5] [RQ17]
    if (realign) begin
      next_charPending = 1'b0; // see [RQ4]
    end
    if (start) begin
      next_charBuf = charDone ? next_shiftReg : pendBuf;
      next_rxHalf = charDone ? next_shiftReg[4:0] : pendBuf[4:0]; // see [RQ8] [RQ6]
      next_pair = sca_pkg::PAIR_FIRST; // see [RQ20] [RQ9]
      next_outState = sca_pkg::OUT_FIRST;
      next_outPhase = 4'h0;
      next_charPending = 1'b0;
    end else begin
      if (charDone) begin
        next_pendBuf = next_shiftReg;
        next_charPending = 1'b1;
      end
      if (bitTick && outState != sca_pkg::OUT_IDLE) begin
        if (outPhase == sca_pkg::CHAR_LAST_IDX) begin
          // hold the pair as is: clock stretched, no short pulse
          next_outState = sca_pkg::OUT_IDLE; // see [RQ4]
        end else begin
          next_outPhase = outPhase + 4'h1;
          if (outPhase == sca_pkg::FIRST_LAST_IDX) begin
            next_rxHalf = charBuf[9:5]; // see [RQ8]
            next_pair = sca_pkg::PAIR_SECOND; // see [RQ20]
            next_outState = sca_pkg::OUT_SECOND;
          end
        end
      end
    end
    case (outState)
      sca_pkg::OUT_IDLE, sca_pkg::OUT_FIRST, sca_pkg::OUT_SECOND: begin
      end
      default: begin
        next_outState = sca_pkg::OUT_IDLE;
      end
    endcase
    if (!rxLocked) begin
      next_rxHalf = 5'h0; // see [RQ15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outState <= sca_pkg::OUT_IDLE;
      outPhase <= 4'h0;
      charBuf <= 10'h0;
      pendBuf <= 10'h0;
      charPending <= 1'b0;
      rxHalf <= 5'h0;
      recoveredByteClockPair <= sca_pkg::PAIR_RESET;
    end else begin
      outState <= next_outState;
      outPhase <= next_outPhase;
      charBuf <= next_charBuf;
      pendBuf <= next_pendBuf;
      charPending <= next_charPending;
      rxHalf <= next_rxHalf;
      recoveredByteClockPair <= next_pair;
    end
  end

  // transmit capture at a quarter period after each byte clock edge
  sca_pkg::sca_tx_state_t txState;
  sca_pkg::sca_tx_state_t next_txState;
  logic [2:0] qCnt;
  logic [2:0] next_qCnt;
  logic txLoad;
  logic next_txLoad;
  logic [4:0] txHalfCap;
  logic [4:0] next_txHalfCap;

  always_comb begin
    next_txState = txState;
    next_qCnt = qCnt;
    next_txLoad = 1'b0;
    next_txHalfCap = txHalfCap;
    case (txState)
      sca_pkg::TX_IDLE: begin
        next_qCnt = 3'h0;
        if (txRise) begin
          next_txState = sca_pkg::TX_FIRST; // see [RQ19]
        end else if (txFall) begin
          next_txState = sca_pkg::TX_SECOND;
        end
      end
      sca_pkg::TX_FIRST, sca_pkg::TX_SECOND: begin
        if (qCnt == 3'(sca_pkg::TX_QUARTER_CYCLES - 1)) begin
          next_txHalfCap = txDat; // see [RQ11]
          next_txLoad = 1'b1;
          next_txState = sca_pkg::TX_IDLE;
        end else begin
          next_qCnt = qCnt + 3'h1;
        end
      end
      default: begin
        next_txState = sca_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState <= sca_pkg::TX_IDLE;
      qCnt <= 3'h0;
      txLoad <= 1'b0;
      txHalfCap <= 5'h0;
    end else begin
      txState <= next_txState;
      qCnt <= next_qCnt;
      txLoad <= next_txLoad;
      txHalfCap <= next_txHalfCap;
    end
  end

  // halves go out in capture order, first half first
  sca_tx_serializer txSer (
    .clk(clk),
    .rst(rst),
    .load(txLoad),
    .half(txHalfCap),
    .serialBit(txSerial),
    .bitStrobe(txSerialStrobe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_comma_sets_index: assert property (bitTick && commaSeen |=> bitIdx == 4'h6 && rxAligned) // see [RQ3]
    else $error("comma did not reset the boundary");
  a_pair_opposite: assert property (recoveredByteClockPair[1] != recoveredByteClockPair[0]) // see [RQ20]
    else $error("recovered clock pair not in opposition");
  a_no_sliver: assert property ($fell(recoveredByteClockPair[1]) |-> $past(outPhase) == 4'h4) // see [RQ4]
    else $error("first phase clock cut short");
  a_second_half: assert property ($rose(recoveredByteClockPair[0]) |-> rxHalf == charBuf[9:5]) // see [RQ8]
    else $error("second half not with phase zero clock");
  a_comma_on_bit0: assert property (start && next_charBuf[6:0] == sca_pkg::COMMA_PREFIX // see [RQ6]
    |=> recoveredByteClockPair == 2'h2 && rxHalf[1:0] == 2'h0 && rxHalf[4:2] == 3'h7)
    else $error("comma not presented on phase one");
  a_held_unlocked: assert property (!rxLocked |-> rxHalf == 5'h0 && outState == sca_pkg::OUT_IDLE) // see [RQ15]
    else $error("output moved before lock");
  a_locked_stays: assert property (rxLocked |=> rxLocked) // see [RQ15]
    else $error("lock dropped");
  a_tx_quarter: assert property (txRise && txState == sca_pkg::TX_IDLE |-> ##5 txLoad) // see [RQ11]
    else $error("transmit capture not a quarter after edge");
  a_unsync_unaligned: assert property (linkLost |=> !rxBitSync ##1 !rxAligned) // see [RQ21] [RQ16]
    else $error("alignment kept after link loss");

  c_realign: cover property (bitTick && realign);
  c_comma_out: cover property (start && next_charBuf[6:0] == sca_pkg::COMMA_PREFIX);
  c_stretch: cover property (outState == sca_pkg::OUT_IDLE && rxLocked ##1 start);
  c_tx_char: cover property (txLoad ##[4:12] txLoad);
endmodule // sca_serdes_align

//--- sca_far_end.sv
`timescale 1ns/1ps
module sca_far_end (
  input wire logic clk, // core clock, paces every link edge
  output logic rxBitClk, // serial bit clock toward the receiver
  output logic rxBitIn, // serial data toward the receiver
  output logic sharedTransmitByteClock, // one byte clock for all transmit channels
  output logic [4:0] txHalfIn // transmit half-character
);
  localparam int HALF_LINK = 8; // 40 ns, half of the 80 ns link period
  logic lastComma;

  // quiet link at time zero
  initial begin
    rxBitClk = 1'b0;
    rxBitIn = 1'b0;
    sharedTransmitByteClock = 1'b0;
    txHalfIn = 5'h00;
    lastComma = 1'b0;
  end

  // data moves with the falling link edge, so it is steady at the rising one
  task automatic sendBit(input logic b);
    rxBitClk = 1'b0;
    rxBitIn = b;
    repeat (HALF_LINK) @(negedge clk);
    rxBitClk = 1'b1;
    repeat (HALF_LINK) @(negedge clk);
  endtask

  // bit zero leaves first; a second comma in a row is dropped
  task automatic sendChar(input logic [9:0] c);
    logic isComma;
    isComma = (c[6:0] == sca_pkg::COMMA_PREFIX);
    if (!(isComma && lastComma)) begin
      for (int i = 0; i < 10; i++) begin
        sendBit(c[i]);
      end
      lastComma = isComma;
    end
  endtask

  // clock stands still, data no longer holds its last value
  task automatic linkIdle();
    rxBitClk = 1'b0;
    rxBitIn = ~rxBitIn;
  endtask

  // first half with the rising byte clock, second with the falling one
  task automatic sendTxChar(input logic [9:0] c);
    sharedTransmitByteClock = 1'b1;
    txHalfIn = c[4:0];
    repeat (HALF_LINK) @(negedge clk);
    sharedTransmitByteClock = 1'b0;
    txHalfIn = c[9:5];
    repeat (HALF_LINK) @(negedge clk);
  endtask

  // released transmit bus shows the inverse pattern
  task automatic txIdle();
    txHalfIn = ~txHalfIn;
  endtask
endmodule // sca_far_end

//--- sca_serdes_align_tb.sv
`timescale 1ns/1ps
module sca_serdes_align_tb;
  localparam int LOCK_SIM = 50;
  localparam int BIT_CYC = 16;
  logic clk;
  logic rst;
  logic rxBitClk;
  logic rxBitIn;
  logic sharedTransmitByteClock;
  logic [4:0] txHalfIn;
  logic [4:0] rxHalf;
  logic [1:0] recoveredByteClockPair;
  logic rxAligned;
  logic rxLocked;
  logic rxBitSync;
  logic txSerial;
  logic txSerialStrobe;
  int errors = 0;
  int checksDone = 0;
  int cyc = 0;
  int pairRun = 1000;
  int minRun = 1000;
  int firstStrobe = 0;
  time firstOut = 0;
  logic [9:0] charQ[$];
  logic txQ[$];
  logic [4:0] lowHalf = 5'h00;
  logic lowAligned = 1'b0;
  logic [1:0] prevPair = 2'h1;
  logic [9:0] expChar [4] = '{10'h17C, 10'h2A5, 10'h17C, 10'h2A5};
  logic [9:0] expTx [3] = '{10'h17C, 10'h2A5, 10'h0F3};

  sca_serdes_align #(.LOCK_CYCLES(LOCK_SIM)) u_sca_serdes_align (
    .clk(clk), .rst(rst), .rxBitClk(rxBitClk), .rxBitIn(rxBitIn),
    .sharedTransmitByteClock(sharedTransmitByteClock), .txHalfIn(txHalfIn),
    .rxHalf(rxHalf), .recoveredByteClockPair(recoveredByteClockPair),
    .rxAligned(rxAligned), .rxLocked(rxLocked), .rxBitSync(rxBitSync),
    .txSerial(txSerial), .txSerialStrobe(txSerialStrobe)
  );

  sca_far_end u_sca_far_end (
    .clk(clk), .rxBitClk(rxBitClk), .rxBitIn(rxBitIn),
    .sharedTransmitByteClock(sharedTransmitByteClock), .txHalfIn(txHalfIn)
  );

  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic endSim();
    $display("errors %0d, checks %0d", errors, checksDone);
    if (errors == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // sample at the falling core edge, after registered outputs settle
  always @(negedge clk) begin
    cyc++;
    if (!rst && rxLocked === 1'b1) begin
      if (recoveredByteClockPair !== prevPair) begin
        chk(recoveredByteClockPair[1] ^ recoveredByteClockPair[0], 1'b1);
        if (pairRun < minRun) minRun = pairRun;
        pairRun = 0;
      end
      // a run spanning loss of bit sync is not a realignment, so it is not measured
      pairRun = (rxBitSync === 1'b1) ? pairRun + 1 : 1000;
      // latch on the rising edge of each phase in turn
      if (recoveredByteClockPair[1] && !prevPair[1]) begin
        lowHalf = rxHalf;
        lowAligned = rxAligned;
        if (charQ.size() == 0 && rxAligned === 1'b1 && firstOut == 0) firstOut = $time;
      end
      if (recoveredByteClockPair[0] && !prevPair[0] && lowAligned && rxAligned === 1'b1) begin
        charQ.push_back({rxHalf, lowHalf});
      end
    end
    prevPair = recoveredByteClockPair;
    if (txSerialStrobe === 1'b1) begin
      if (txQ.size() == 0) firstStrobe = cyc;
      txQ.push_back(txSerial);
    end
  end

  // reset state, then lock only after the shortened wait
  task automatic testResetLock();
    int n;
    n = 0;
    chk(rxHalf, 5'h00);
    chk(recoveredByteClockPair, sca_pkg::PAIR_RESET);
    chk({rxAligned, rxLocked, rxBitSync, txSerialStrobe}, 4'h0);
    while (rxLocked !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
      if (n == LOCK_SIM - 3) chk(recoveredByteClockPair, sca_pkg::PAIR_RESET);
    end
    chk(n >= LOCK_SIM - 1 && n <= LOCK_SIM + 2, 1'b1);
    // bound used up: already counted, go straight to the report
    if (rxLocked !== 1'b1) endSim();
  endtask

  // near miss, then comma, data, comma: framing and order of the halves
  task automatic testRxAlign();
    time t0;
    u_sca_far_end.sendBit(1'b1);
    u_sca_far_end.sendBit(1'b0);
    u_sca_far_end.sendBit(1'b1);
    u_sca_far_end.sendChar(10'h2BC);
    u_sca_far_end.sendChar(10'h2A5);
    u_sca_far_end.sendChar(10'h2A5);
    chk(rxAligned, 1'b0);
    charQ.delete();
    firstOut = 0;
    t0 = $time;
    for (int i = 0; i < 4; i++) begin
      u_sca_far_end.sendChar(expChar[i]);
    end
    u_sca_far_end.sendChar(10'h2A5);
    u_sca_far_end.sendChar(10'h2A5);
    chk(rxAligned, 1'b1);
    chk(charQ.size() >= 4, 1'b1);
    for (int i = 0; i < 4; i++) begin
      chk(charQ[i], expChar[i]);
    end
    chk(firstOut - t0 <= 20 * 80, 1'b1);
  endtask

  // link stops beyond the loss limit, then bits resume without a comma
  task automatic testLinkLoss();
    int n;
    n = 0;
    u_sca_far_end.linkIdle();
    while (rxBitSync !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(rxBitSync, 1'b0);
    if (rxBitSync !== 1'b0) endSim();
    // alignment drops one cycle after bit sync
    @(negedge clk);
    chk(rxAligned, 1'b0);
    for (int i = 0; i < 3; i++) begin
      u_sca_far_end.sendChar(10'h2A5);
    end
    chk(rxBitSync, 1'b1);
    chk(rxAligned, 1'b0);
  endtask

  // reset in mid-run: outputs fall back at once, lock starts over
  task automatic testMidReset();
    rst = 1'b1;
    @(negedge clk);
    chk({rxHalf, recoveredByteClockPair}, {5'h00, sca_pkg::PAIR_RESET});
    chk({rxAligned, rxLocked, rxBitSync, txSerialStrobe}, 4'h0);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    testResetLock();
  endtask

  // three characters through the transmit path, bit zero first
  task automatic testTx();
    int t0;
    txQ.delete();
    t0 = cyc;
    for (int i = 0; i < 3; i++) begin
      u_sca_far_end.sendTxChar(expTx[i]);
    end
    u_sca_far_end.txIdle();
    repeat (30) @(negedge clk);
    chk(txQ.size(), 30);
    for (int i = 0; i < 30 && i < txQ.size(); i++) begin
      chk(txQ[i], expTx[i / 10][i % 10]);
    end
    chk(firstStrobe - t0 >= 4 && firstStrobe - t0 <= 14, 1'b1);
  endtask

  // no hang outlives the cycle budget
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    endSim();
  end

  initial begin
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    testResetLock();
    testRxAlign();
    testLinkLoss();
    testRxAlign();
    u_sca_far_end.linkIdle();
    testMidReset();
    testTx();
    chk(minRun >= 5 * BIT_CYC, 1'b1);
    endSim();
  end
endmodule // sca_serdes_align_tb
